// file: src/srb_pkg.sv
// package: register map, field positions, reset values and timing for the soft reset / boot select block
package srb_pkg;
    // special function register addresses
    localparam logic [7:0] ADDR_CHIP_CONTROL = 8'h9f;
    localparam logic [7:0] ADDR_AUX_ONE = 8'ha2;
    localparam logic [7:0] ADDR_TIMED_KEY = 8'hc7;   // timed access key register
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'hf8;  // sticky event bits, write one to clear
    localparam logic [7:0] ADDR_IRQ_MASK = 8'hf9;    // event enables
    localparam logic [7:0] ADDR_CONFIG_ZERO = 8'hfa; // read-only view of the config byte
    // timed access key values
    localparam logic [7:0] KEY_FIRST = 8'haa;
    localparam logic [7:0] KEY_SECOND = 8'h55;
    // field positions
    localparam int TRIGGER_BIT = 7;
    localparam int BOOT_SELECT_BIT = 1;
    localparam int FLAG_BIT = 7;
    localparam int CONFIG_BOOT_BIT = 7;
    // event bits of the interrupt status register
    localparam int EV_SOFT_RESET = 0;
    localparam int EV_KEY_FAULT = 1;
    localparam int EV_COUNT = 2;
    // reset values
    localparam logic [7:0] CONFIG_FACTORY = 8'hff;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [7:0] SP_RESET = 8'h07;
    localparam logic [7:0] PORT_LATCH_RESET = 8'hff;
    // timing
    localparam int CLK_MHZ = 125;
    localparam int HOLD_CYCLES = 16;          // internal reset hold after a soft trigger
    localparam int DEBUG_QUASI_LOW_SPEED_RC_OSC = 600;    // low speed clocks with debug pins in quasi mode
    typedef enum logic [1:0] {
        SRB_RUN,
        SRB_DRAIN,
        SRB_HOLD
    } srb_state_t;
endpackage : srb_pkg

// file: src/srb_core.sv
// design: soft reset trigger, reset source flag, boot block selection and post-reset state
//
// Behaviour
// - trigger bit write resets whole system
// - trigger needs AA then 55 key first
// - triggering instruction completes, nothing after executes
// - trigger write-only, cleared after reset completes
// - soft reset sets flag bit seven
// - flag survives resets except power-on, software clears it
// - boot select zero means application flash
// - non-soft resets load inverted config bit
// - config bit one selects application flash
// - boot decision uses register bit only
// - RAM kept except after power-on
// - program counter held zero during reset
// - stack pointer loads 07H on reset
// - ports FFH, input-only, peripherals disabled
// - debug pins quasi for 600 slow clocks
`timescale 1ns/100ps
`default_nettype none
module srb_core #(
    parameter int HOLD = srb_pkg::HOLD_CYCLES,
    parameter int QUASI_TICKS = srb_pkg::DEBUG_QUASI_LOW_SPEED_RC_OSC
) (
    input wire logic clk,
    input wire logic reset,               // power-on reset, async active high
    input wire logic ext_reset_req,       // other reset sources (pin, watchdog...), asynchronous level
    input wire logic low_speed_rc_osc_tick,           // one pulse per low speed oscillator clock, same domain
    input wire logic instr_done,          // core reports end of the current instruction
    input wire logic [7:0] cfg_byte,      // hardware config zero, static
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    output logic irq,
    output logic sys_reset,               // internal reset to the whole system
    output logic core_stall,              // stops fetching the next instruction
    output logic ram_valid,               // low after power-on until software may trust RAM
    output logic boot_from_loader,        // boot block chosen at reset release
    output logic [15:0] pc_start,
    output logic [7:0] sp_start,
    output logic [7:0] port_latch,
    output logic port_input_only,
    output logic periph_enable,
    output logic debug_pins_quasi
);
    // *********************************************
    // input synchroniser for the asynchronous reset request
    // *********************************************
    logic [2:0] ext_sync_reg;   // stage 0 read only by stage 1
    logic ext_level_reg;        // filtered level, changes once stages agree
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ext_sync_reg <= 3'h0;
            ext_level_reg <= 1'b0;
        end else begin
            ext_sync_reg <= {ext_sync_reg[1:0], ext_reset_req};
            if (ext_sync_reg[2] == ext_sync_reg[1]) begin
                ext_level_reg <= ext_sync_reg[2];
            end
        end
    end

    // *********************************************
    // timed access key tracking
    // *********************************************
    // key progress: idle, first key seen, open for exactly the next write
    typedef enum logic [1:0] {
        SRB_KEY_IDLE,
        SRB_KEY_HALF,
        SRB_KEY_OPEN
    } srb_key_t;
    srb_key_t key_reg;
    logic unlocked;
    logic key_fault;
    assign unlocked = (key_reg == SRB_KEY_OPEN);
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            key_reg <= SRB_KEY_IDLE;
        end else if (wr) begin
            if (addr == srb_pkg::ADDR_TIMED_KEY && wdata == srb_pkg::KEY_FIRST) begin
                key_reg <= SRB_KEY_HALF;
            end else if (addr == srb_pkg::ADDR_TIMED_KEY && wdata == srb_pkg::KEY_SECOND
                         && key_reg == SRB_KEY_HALF) begin
                key_reg <= SRB_KEY_OPEN;
            end else begin
                // any other write spends or breaks the key
                key_reg <= SRB_KEY_IDLE;
            end
        end
    end
    // protected write to chip control without the key
    assign key_fault = wr && addr == srb_pkg::ADDR_CHIP_CONTROL && !unlocked;

    // *********************************************
    // soft reset sequencer
    // *********************************************
    srb_pkg::srb_state_t state_reg;
    logic [$clog2(HOLD+1)-1:0] hold_reg;
    logic trigger_reg;         // write-only trigger, readback always zero
    logic trig_write;
    logic soft_done;           // one cycle at the end of the hold
    assign trig_write = wr && addr == srb_pkg::ADDR_CHIP_CONTROL && unlocked
                        && wdata[srb_pkg::TRIGGER_BIT];
    assign soft_done = (state_reg == srb_pkg::SRB_HOLD) && (hold_reg == '0);
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_reg <= srb_pkg::SRB_RUN;
            hold_reg <= '0;
            trigger_reg <= 1'b0;
        end else begin
            unique case (state_reg)
                srb_pkg::SRB_RUN: begin
                    if (trig_write) begin
                        trigger_reg <= 1'b1;
                        state_reg <= srb_pkg::SRB_DRAIN;
                    end
                end
                srb_pkg::SRB_DRAIN: begin
                    // let the setting instruction finish, then reset
                    if (instr_done) begin
                        state_reg <= srb_pkg::SRB_HOLD;
                        hold_reg <= ($clog2(HOLD+1))'(HOLD - 1);
                    end
                end
                srb_pkg::SRB_HOLD: begin
                    if (hold_reg == '0) begin
                        state_reg <= srb_pkg::SRB_RUN;
                        trigger_reg <= 1'b0;
                    end else begin
                        hold_reg <= hold_reg - 1'b1;
                    end
                end
            endcase
        end
    end

    // *********************************************
    // system reset output and stall
    // *********************************************
    // system reset covers soft hold and filtered external request
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sys_reset <= 1'b1;
            core_stall <= 1'b1;
        end else begin
            sys_reset <= (state_reg == srb_pkg::SRB_HOLD && !soft_done) || ext_level_reg;
            // trigger stays set from the accepted write to the end of the hold
            core_stall <= trigger_reg || trig_write || ext_level_reg;
        end
    end

    // *********************************************
    // reset source flag and boot select
    // *********************************************
    logic flag_reg;
    logic boot_sel_reg;
    logic boot_init_reg;   // config load pending after power-on
    logic boot_take_reg;   // power-on latch of the boot block, one edge after the load
    logic ext_prev_reg;
    logic ext_fall;
    assign ext_fall = ext_prev_reg && !ext_level_reg;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            flag_reg <= 1'b0;
            ext_prev_reg <= 1'b0;
        end else begin
            ext_prev_reg <= ext_level_reg;
            if (soft_done) begin
                flag_reg <= 1'b1;
            end else if (wr && addr == srb_pkg::ADDR_AUX_ONE) begin
                flag_reg <= wdata[srb_pkg::FLAG_BIT];
            end
        end
    end
    // boot select: reloaded from inverted config on every reset except soft one
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            boot_sel_reg <= 1'b0;
            boot_init_reg <= 1'b1;
            boot_take_reg <= 1'b0;
        end else begin
            boot_init_reg <= 1'b0;
            boot_take_reg <= boot_init_reg;
            if (boot_init_reg || ext_level_reg) begin
                boot_sel_reg <= ~cfg_byte[srb_pkg::CONFIG_BOOT_BIT];
            end else if (wr && addr == srb_pkg::ADDR_CHIP_CONTROL && unlocked) begin
                boot_sel_reg <= wdata[srb_pkg::BOOT_SELECT_BIT];
            end
        end
    end
    // boot block latched at release from the register bit only
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            boot_from_loader <= 1'b0;
        end else if (soft_done || ext_fall || boot_take_reg) begin
            boot_from_loader <= boot_sel_reg;
        end
    end
    // config one selects application, zero loader, through the inversion above

    // *********************************************
    // post-reset core state
    // *********************************************
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pc_start <= srb_pkg::PC_RESET;
            sp_start <= srb_pkg::SP_RESET;
            port_latch <= srb_pkg::PORT_LATCH_RESET;
            port_input_only <= 1'b1;
            periph_enable <= 1'b0;
        end else begin
            // start address is 0000H in whichever block is selected
            pc_start <= srb_pkg::PC_RESET;
            if (sys_reset) begin
                sp_start <= srb_pkg::SP_RESET;
                port_latch <= srb_pkg::PORT_LATCH_RESET;
                port_input_only <= 1'b1;
                periph_enable <= 1'b0;
            end else begin
                periph_enable <= 1'b1;
            end
        end
    end
    // ram untrusted only after power-on; other resets keep contents
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ram_valid <= 1'b0;
        end else if (wr && addr == srb_pkg::ADDR_AUX_ONE) begin
            ram_valid <= 1'b1;
        end
    end

    // *********************************************
    // debug pin quasi window
    // *********************************************
    logic [$clog2(QUASI_TICKS+1)-1:0] quasi_reg;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            quasi_reg <= '0;
            debug_pins_quasi <= 1'b1;
        end else if (sys_reset) begin
            quasi_reg <= '0;
            debug_pins_quasi <= 1'b1;
        end else if (debug_pins_quasi && low_speed_rc_osc_tick) begin
            if (quasi_reg == ($clog2(QUASI_TICKS+1))'(QUASI_TICKS - 1)) begin
                debug_pins_quasi <= 1'b0;
            end
            quasi_reg <= quasi_reg + 1'b1;
        end
    end

    // *********************************************
    // interrupt status and mask
    // *********************************************
    logic [srb_pkg::EV_COUNT-1:0] ev_status_reg;
    logic [srb_pkg::EV_COUNT-1:0] ev_mask_reg;
    logic [srb_pkg::EV_COUNT-1:0] ev_set;
    logic [srb_pkg::EV_COUNT-1:0] ev_clr;
    always_comb begin
        ev_set = '0;
        ev_set[srb_pkg::EV_SOFT_RESET] = soft_done;
        ev_set[srb_pkg::EV_KEY_FAULT] = key_fault;
        ev_clr = (wr && addr == srb_pkg::ADDR_IRQ_STATUS) ? wdata[srb_pkg::EV_COUNT-1:0] : '0;
    end
    // set wins over a clear in the same cycle
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ev_status_reg <= '0;
            ev_mask_reg <= '0;
            irq <= 1'b0;
        end else begin
            ev_status_reg <= (ev_status_reg & ~ev_clr) | ev_set;
            if (wr && addr == srb_pkg::ADDR_IRQ_MASK) begin
                ev_mask_reg <= wdata[srb_pkg::EV_COUNT-1:0];
            end
            irq <= |(((ev_status_reg & ~ev_clr) | ev_set) & ev_mask_reg);
        end
    end

    // *********************************************
    // read port, data one cycle after strobe
    // *********************************************
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rdata <= srb_pkg::ZERO_BYTE;
        end else if (rd) begin
            unique case (addr)
                srb_pkg::ADDR_CHIP_CONTROL: rdata <= {6'h00, boot_sel_reg, 1'b0}; // trigger reads zero
                srb_pkg::ADDR_AUX_ONE: rdata <= {flag_reg, 7'h00};
                srb_pkg::ADDR_IRQ_STATUS: rdata <= {6'h00, ev_status_reg};
                srb_pkg::ADDR_IRQ_MASK: rdata <= {6'h00, ev_mask_reg};
                srb_pkg::ADDR_CONFIG_ZERO: rdata <= cfg_byte;
                default: rdata <= srb_pkg::ZERO_BYTE;
            endcase
        end else begin
            rdata <= srb_pkg::ZERO_BYTE;
        end
    end

    // *********************************************
    // checks
    // *********************************************
    a_trigger_key_needed: assert property (@(posedge clk) disable iff (reset)
        (wr && addr == srb_pkg::ADDR_CHIP_CONTROL && key_reg != SRB_KEY_OPEN && state_reg == srb_pkg::SRB_RUN)
        |=> state_reg == srb_pkg::SRB_RUN)
        else $error("unprotected trigger accepted");
    a_soft_reset_asserts: assert property (@(posedge clk) disable iff (reset)
        (state_reg == srb_pkg::SRB_DRAIN && instr_done) |=> ##1 sys_reset)
        else $error("soft reset not applied");
    a_stall_after_trigger: assert property (@(posedge clk) disable iff (reset)
        trig_write |=> core_stall)
        else $error("core not stalled after trigger");
    a_trigger_cleared: assert property (@(posedge clk) disable iff (reset)
        soft_done |=> !trigger_reg)
        else $error("trigger not cleared");
    a_flag_set_soft: assert property (@(posedge clk) disable iff (reset)
        soft_done |=> flag_reg)
        else $error("soft flag not set");
    a_boot_reload: assert property (@(posedge clk) disable iff (reset)
        ext_level_reg |=> boot_sel_reg == ~cfg_byte[srb_pkg::CONFIG_BOOT_BIT])
        else $error("boot select not reloaded");
    a_boot_soft_keep: assert property (@(posedge clk) disable iff (reset)
        soft_done |=> boot_from_loader == $past(boot_sel_reg))
        else $error("boot block not taken from register");
    a_reset_stack: assert property (@(posedge clk) disable iff (reset)
        sys_reset |=> sp_start == srb_pkg::SP_RESET && port_latch == srb_pkg::PORT_LATCH_RESET)
        else $error("stack or ports not reset");
    a_hold_length: assert property (@(posedge clk) disable iff (reset)
        $rose(sys_reset) && !ext_level_reg |-> sys_reset[*2])
        else $error("reset hold too short");
    // helper: length of the last internal reset pulse, saturating
    logic [$clog2(HOLD+1)-1:0] rst_len_reg;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rst_len_reg <= '0;
        end else if (!sys_reset) begin
            rst_len_reg <= '0;
        end else if (rst_len_reg != '1) begin
            rst_len_reg <= rst_len_reg + 1'b1;
        end
    end
    // a soft hold gives exactly HOLD-1 cycles of internal reset
    a_hold_exact: assert property (@(posedge clk) disable iff (reset)
        $fell(sys_reset) && $past(soft_done) |-> rst_len_reg == ($clog2(HOLD+1))'(HOLD - 1))
        else $error("soft reset hold length wrong");
    // reset forces the start address, port mode and peripheral state
    a_pc_zero_reset: assert property (@(posedge clk) disable iff (reset)
        sys_reset |=> pc_start == srb_pkg::PC_RESET)
        else $error("start address not zero in reset");
    a_periph_off_reset: assert property (@(posedge clk) disable iff (reset)
        sys_reset |=> !periph_enable && port_input_only)
        else $error("peripherals or port mode not reset");
    // every internal reset restarts the debug pin window
    a_quasi_restart: assert property (@(posedge clk) disable iff (reset)
        sys_reset |=> debug_pins_quasi && quasi_reg == '0)
        else $error("debug pin window not restarted");
    // only power-on may take ram out of trust
    a_ram_kept: assert property (@(posedge clk) disable iff (reset)
        !$fell(ram_valid))
        else $error("ram trust lost without power-on");
    // a refused protected write leaves a sticky fault bit
    a_fault_event: assert property (@(posedge clk) disable iff (reset)
        key_fault |=> ev_status_reg[srb_pkg::EV_KEY_FAULT])
        else $error("key fault not recorded");
    // power-on loads the inverted config bit, then boots from the register bit
    a_boot_power_load: assert property (@(posedge clk) disable iff (reset)
        boot_init_reg |=> boot_sel_reg == ~cfg_byte[srb_pkg::CONFIG_BOOT_BIT])
        else $error("boot select not loaded at power-on");
    a_boot_power_take: assert property (@(posedge clk) disable iff (reset)
        boot_take_reg |=> boot_from_loader == $past(boot_sel_reg))
        else $error("power-on boot block not taken from register");
    // other resets leave the source flag alone
    a_flag_kept_ext: assert property (@(posedge clk) disable iff (reset)
        ext_level_reg && !soft_done && !(wr && addr == srb_pkg::ADDR_AUX_ONE) |=> flag_reg == $past(flag_reg))
        else $error("soft flag changed by another reset");
endmodule : srb_core
`default_nettype wire

// file: test/soft_reset_boot_select_tb.sv
// testbench: register port, soft reset trigger, boot selection and reset state of srb_core
`timescale 1ns/100ps
`default_nettype none
module soft_reset_boot_select_tb;
    // ****************************************
    // signals and shortened timing
    // ****************************************
    localparam int HOLD_T = 6;      // short reset hold keeps the run brief
    localparam int QUASI_T = 4;     // short debug pin quasi window
    logic clk, reset, ext_reset_req, low_speed_rc_osc_tick, instr_done, wr, rd;
    logic [7:0] cfg_byte, addr, wdata, rdata, sp_start, port_latch;
    logic irq, sys_reset, core_stall, ram_valid, boot_from_loader;
    logic port_input_only, periph_enable, debug_pins_quasi;
    logic [15:0] pc_start;
    logic rd_d;                     // read strobe delayed: read data stands now
    logic [7:0] exp_q[$];           // expected read data, oldest first
    logic [7:0] exp_v;
    int err_total, comparisons, seed, cyc;

    srb_core #(.HOLD(HOLD_T), .QUASI_TICKS(QUASI_T)) uut (
        .clk(clk), .reset(reset), .ext_reset_req(ext_reset_req), .low_speed_rc_osc_tick(low_speed_rc_osc_tick),
        .instr_done(instr_done), .cfg_byte(cfg_byte), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .irq(irq), .sys_reset(sys_reset), .core_stall(core_stall), .ram_valid(ram_valid),
        .boot_from_loader(boot_from_loader), .pc_start(pc_start), .sp_start(sp_start),
        .port_latch(port_latch), .port_input_only(port_input_only), .periph_enable(periph_enable),
        .debug_pins_quasi(debug_pins_quasi)
    );

    // ****************************************
    // clock, slow oscillator ticks, hang guard
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // one slow tick every four cycles; ceiling far above the expected run
    always @(posedge clk) begin
        cyc <= cyc + 1;
        low_speed_rc_osc_tick <= (cyc % 4 == 3);
        if (cyc >= 5000) begin
            err_total++;
            wrap_up();
        end
    end

    // ****************************************
    // read watcher and shared tasks
    // ****************************************
    // read data stands only in the cycle after the strobe, so compare it there
    always @(posedge clk) begin
        rd_d <= rd;
        if (rd_d) begin
            exp_v = exp_q.pop_front();
            comparisons++;
            if (rdata !== exp_v) begin
                err_total++;
                $display("MISMATCH t=%0t got=%h exp=%h", $time, rdata, exp_v);
            end
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] e);
        comparisons++;
        if (got !== e) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, e);
        end
    endtask : chk

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk);
        rd <= 1'b0;
    endtask : rd_reg

    task automatic cycles(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cycles

    // bounded wait for the internal reset to reach a level
    task automatic wait_rst(input logic v);
        int k;
        for (k = 0; k < 64 && sys_reset !== v; k++) begin
            @(posedge clk);
            #1;
        end
        chk(16'(sys_reset), 16'(v));
    endtask : wait_rst

    task automatic wrap_up();
        $display("err_total=%0d comparisons=%0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : wrap_up

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        int n;
        seed = 40;
        err_total = 0;
        comparisons = 0;
        cyc = 0;
        rd_d = 1'b0;
        reset = 1'b1;
        ext_reset_req = 1'b0;
        low_speed_rc_osc_tick = 1'b0;
        instr_done = 1'b0;
        cfg_byte = 8'hff;           // factory value: application flash
        addr = 8'h00;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        cycles(6);
        chk(pc_start, 16'h0000);
        chk(16'(sp_start), 16'h0007);
        chk(16'(port_latch), 16'h00ff);
        chk(16'(port_input_only), 16'h0001);
        chk(16'(periph_enable), 16'h0000);
        @(posedge clk);
        reset <= 1'b0;
        cycles(3);
        chk(16'(sys_reset), 16'h0000);
        chk(16'(boot_from_loader), 16'h0000);
        chk(16'(debug_pins_quasi), 16'h0001);
        chk(16'(periph_enable), 16'h0001);
        chk(16'(ram_valid), 16'h0000);
        cycles(20);
        chk(16'(debug_pins_quasi), 16'h0000);
        rd_reg(srb_pkg::ADDR_CHIP_CONTROL, 8'h00);
        rd_reg(srb_pkg::ADDR_AUX_ONE, 8'h00);
        rd_reg(srb_pkg::ADDR_CONFIG_ZERO, 8'hff);
        rd_reg(8'h10, 8'h00);
        // unprotected trigger, then a key broken by a write in between
        wr_reg(srb_pkg::ADDR_CHIP_CONTROL, 8'($random(seed)) | 8'h80);
        cycles(3);
        chk(16'(core_stall), 16'h0000);
        wr_reg(srb_pkg::ADDR_TIMED_KEY, srb_pkg::KEY_FIRST);
        wr_reg(srb_pkg::ADDR_TIMED_KEY, srb_pkg::KEY_SECOND);
        wr_reg(srb_pkg::ADDR_AUX_ONE, 8'h00);
        wr_reg(srb_pkg::ADDR_CHIP_CONTROL, 8'h80);
        cycles(3);
        chk(16'(core_stall), 16'h0000);
        // key fault event: sticky, masked, unmasked, cleared
        rd_reg(srb_pkg::ADDR_IRQ_STATUS, 8'h02);
        chk(16'(irq), 16'h0000);
        wr_reg(srb_pkg::ADDR_IRQ_MASK, 8'h02);
        cycles(2);
        chk(16'(irq), 16'h0001);
        wr_reg(srb_pkg::ADDR_IRQ_STATUS, 8'h02);
        cycles(2);
        chk(16'(irq), 16'h0000);
        rd_reg(srb_pkg::ADDR_IRQ_STATUS, 8'h00);
        wr_reg(srb_pkg::ADDR_IRQ_MASK, 8'h01);
        // keyed trigger that also sets the boot select bit
        wr_reg(srb_pkg::ADDR_TIMED_KEY, srb_pkg::KEY_FIRST);
        wr_reg(srb_pkg::ADDR_TIMED_KEY, srb_pkg::KEY_SECOND);
        wr_reg(srb_pkg::ADDR_CHIP_CONTROL, 8'h82);
        cycles(2);
        chk(16'(core_stall), 16'h0001);
        cycles(4);
        chk(16'(sys_reset), 16'h0000);
        @(posedge clk);
        instr_done <= 1'b1;
        @(posedge clk);
        instr_done <= 1'b0;
        wait_rst(1'b1);
        for (n = 0; n < 64 && sys_reset === 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
        chk(16'(n), 16'(HOLD_T - 1));
        cycles(2);
        chk(16'(boot_from_loader), 16'h0001);
        chk(16'(irq), 16'h0001);
        chk(16'(core_stall), 16'h0000);
        chk(16'(ram_valid), 16'h0001);
        rd_reg(srb_pkg::ADDR_CHIP_CONTROL, 8'h02);
        rd_reg(srb_pkg::ADDR_AUX_ONE, 8'h80);
        rd_reg(srb_pkg::ADDR_IRQ_STATUS, 8'h01);
        // other reset source: boot select reloaded, flag and RAM kept
        @(posedge clk);
        ext_reset_req <= 1'b1;
        wait_rst(1'b1);
        cycles(4);
        @(posedge clk);
        ext_reset_req <= 1'b0;
        wait_rst(1'b0);
        cycles(2);
        chk(16'(boot_from_loader), 16'h0000);
        chk(16'(ram_valid), 16'h0001);
        rd_reg(srb_pkg::ADDR_CHIP_CONTROL, 8'h00);
        rd_reg(srb_pkg::ADDR_AUX_ONE, 8'h80);
        wr_reg(srb_pkg::ADDR_AUX_ONE, 8'h00);
        rd_reg(srb_pkg::ADDR_AUX_ONE, 8'h00);
        // second power-on with config selecting the loader
        @(posedge clk);
        cfg_byte <= 8'h7f;
        reset <= 1'b1;
        cycles(4);
        @(posedge clk);
        reset <= 1'b0;
        cycles(3);
        chk(16'(boot_from_loader), 16'h0001);
        chk(16'(ram_valid), 16'h0000);
        rd_reg(srb_pkg::ADDR_CHIP_CONTROL, 8'h02);
        cycles(3);
        wrap_up();
    end
endmodule : soft_reset_boot_select_tb
`default_nettype wire
